// ==== design/oma_pkg.sv ====
// Purpose: shared constants for the on-chip memory access port and its host
// Assumes: 8-bit register space on the link, 32-bit APB on the host side
// Notes:   link register offsets follow the device register map
package oma_pkg;
	localparam logic [7:0] ADDR_CTRL   = 8'h88;
	localparam logic [7:0] ADDR_MEM_HI = 8'h8b;
	localparam logic [7:0] ADDR_MEM_LO = 8'h8c;
	localparam logic [7:0] ADDR_ROM    = 8'h8f;
	localparam logic [7:0] ADDR_UNLOCK = 8'h90;
	localparam logic [7:0] ADDR_PAGE   = 8'h91;
	localparam logic [7:0] ADDR_CAP_HI = 8'hc7;
	localparam logic [7:0] ADDR_CAP_LO = 8'hc8;

	localparam logic [7:0] UNLOCK_KEY  = 8'hea;
	localparam logic [7:0] RESET_BYTE  = 8'h00;
	localparam int CTRL_PROG_BIT = 0;
	localparam int CTRL_SNAP_BIT = 1;
	localparam int CTRL_BUSY_BIT = 2;

	localparam int NUM_PAGES   = 6;
	localparam int PAGE_W      = 4;
	localparam int MEM_ADDR_W  = 12;
	localparam int CAP_W       = 10;
	localparam int BOOT_W      = 2;
	localparam int PROG_CYCLES = 16;

	localparam logic [11:0] HOST_CMD  = 12'h000;
	localparam logic [11:0] HOST_ARG  = 12'h004;
	localparam logic [11:0] HOST_STAT = 12'h008;

	typedef enum logic [1:0] {
		OP_WRITE = 2'b00,
		OP_READ  = 2'b01,
		OP_PROG  = 2'b10,
		OP_SNAP  = 2'b11
	} oma_op_t;
endpackage

// ==== design/oma_link_if.sv ====
// Purpose: register transaction link between host controller and device
// Assumes: both ends on clk_sys; one strobe per cycle at most
// Notes:   txn_act high spans one bus transaction, start to stop
`timescale 1ns/1ps
interface oma_link_if;
	logic       txn_act;
	logic       addr_load;
	logic [7:0] reg_addr;
	logic       wr_stb;
	logic [7:0] wr_data;
	logic       rd_stb;
	logic       rd_valid;
	logic [7:0] rd_data;

	modport host (
		output txn_act,
		output addr_load,
		output reg_addr,
		output wr_stb,
		output wr_data,
		output rd_stb,
		input  rd_valid,
		input  rd_data
	);

	modport dev (
		input  txn_act,
		input  addr_load,
		input  reg_addr,
		input  wr_stb,
		input  wr_data,
		input  rd_stb,
		output rd_valid,
		output rd_data
	);
endinterface

// ==== design/oma_dev.sv ====
// Purpose: device end - register file with rom stream window, program
//          unlock, snapshot page select and load-cap read-back
// Assumes: link strobes are synchronous to clk_sys
// Notes:   rom contents are a fixed pattern standing in for the mask rom
// How it works
// - first rom window read returns byte at pointer
// - direct or auto-incremented arrival both count first
// - later accesses advance rom pointer, read next
// - register address frozen on rom window afterwards
// - stream ends with transaction; next starts normal
// - program starts only right after unlock write
// - unlock key byte must be 0xea
// - page field picks snapshot target region
// - host writes only pages 0 to 5
// - six pages; two pins pick power-up page
// - load-cap setting read-only, split high/low
// - six configuration pages plus common region
// - host writes zero into reserved bits
// - memory pointer split low byte / high bits
`timescale 1ns/1ps
module oma_dev #(
	parameter int PROG_CYCLES = oma_pkg::PROG_CYCLES
) (
	input  wire logic                          clk_sys,
	input  wire logic                          reset,
	oma_link_if.dev                            link,
	input  wire logic [oma_pkg::CAP_W-1:0]     xo_cap_value,
	input  wire logic [oma_pkg::BOOT_W-1:0]    boot_sel_pins,
	output logic                               prog_pulse,
	output logic                               prog_busy,
	output logic                               snap_pulse,
	output logic [oma_pkg::PAGE_W-1:0]         snap_page,
	output logic [oma_pkg::BOOT_W-1:0]         boot_page
);
	import oma_pkg::*;

	logic [7:0]            reg_ptr_reg;
	logic                  rom_lock_reg;
	logic [MEM_ADDR_W-1:0] rom_addr_reg;
	logic [MEM_ADDR_W-1:0] mem_ptr_reg;
	logic [7:0]            unlock_reg;
	logic                  armed_reg;
	logic [PAGE_W-1:0]     page_reg;
	logic [7:0]            rd_data_reg;
	logic                  rd_valid_reg;
	logic [15:0]           busy_cnt_reg;
	logic                  prog_pulse_reg;
	logic                  snap_pulse_reg;
	logic [PAGE_W-1:0]     snap_page_reg;
	logic                  boot_taken_reg;
	logic [BOOT_W-1:0]     boot_page_reg;

	logic                  access;
	logic                  rom_hit;
	logic                  wr_reg;
	logic                  wr_ctrl;
	logic [MEM_ADDR_W-1:0] rom_now;
	logic [7:0]            rd_mux;
	logic                  busy;

	// stand-in mask rom pattern; a real part would place its table here
	function automatic logic [7:0] rom_byte(input logic [MEM_ADDR_W-1:0] a);
		rom_byte = a[7:0] ^ {a[11:8], a[11:8]};
	endfunction

	assign access  = link.txn_act & (link.wr_stb | link.rd_stb);
	assign rom_hit = (reg_ptr_reg == ADDR_ROM);
	// first access uses the pointer, later ones the next rom byte
	assign rom_now = rom_lock_reg ? rom_addr_reg + 12'h001
		: mem_ptr_reg;
	// writes into the rom window carry no data anywhere
	assign wr_reg  = link.txn_act & link.wr_stb & ~rom_hit;
	assign wr_ctrl = wr_reg & (reg_ptr_reg == ADDR_CTRL);
	assign busy    = (busy_cnt_reg != 16'h0000);

	// register pointer: set by the address phase, auto-increments unless
	// the rom window has taken over the transaction
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reg_ptr_reg <= 8'h00;
		end else if (link.txn_act & link.addr_load & ~rom_lock_reg) begin
			reg_ptr_reg <= link.reg_addr;
		end else if (access & ~rom_hit) begin
			reg_ptr_reg <= reg_ptr_reg + 8'h01;
		end
		// on the rom window the pointer simply holds
	end

	// rom streaming lock lives only while the transaction lasts
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rom_lock_reg <= 1'b0;
		end else if (~link.txn_act) begin
			rom_lock_reg <= 1'b0;
		end else if (access & rom_hit) begin
			rom_lock_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rom_addr_reg <= '0;
		end else if (access & rom_hit) begin
			rom_addr_reg <= rom_now;
		end
	end

	// memory pointer, high nibble and low byte in separate registers
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mem_ptr_reg <= '0;
		end else if (wr_reg & (reg_ptr_reg == ADDR_MEM_HI)) begin
			mem_ptr_reg[11:8] <= link.wr_data[3:0];
		end else if (wr_reg & (reg_ptr_reg == ADDR_MEM_LO)) begin
			mem_ptr_reg[7:0] <= link.wr_data;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			unlock_reg <= RESET_BYTE;
		end else if (wr_reg & (reg_ptr_reg == ADDR_UNLOCK)) begin
			unlock_reg <= link.wr_data;
		end
	end

	// every register write re-decides the arm, so only an unlock write
	// with the key directly before the control write leaves it set
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			armed_reg <= 1'b0;
		end else if (link.txn_act & link.wr_stb) begin
			armed_reg <= wr_reg & (reg_ptr_reg == ADDR_UNLOCK)
				& (link.wr_data == UNLOCK_KEY);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			page_reg <= '0;
		end else if (wr_reg & (reg_ptr_reg == ADDR_PAGE)) begin
			page_reg <= link.wr_data[PAGE_W-1:0];
		end
	end

	// program cycle: needs the arm, refused while a cycle still runs
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			prog_pulse_reg <= 1'b0;
		end else begin
			prog_pulse_reg <= wr_ctrl & link.wr_data[CTRL_PROG_BIT]
				& armed_reg & ~busy;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			busy_cnt_reg <= 16'h0000;
		end else if (prog_pulse_reg) begin
			busy_cnt_reg <= 16'(PROG_CYCLES);
		end else if (busy) begin
			busy_cnt_reg <= busy_cnt_reg - 16'h0001;
		end
	end

	// snapshot to the selected page; an out-of-range page is dropped
	// rather than landing on the common region
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			snap_pulse_reg <= 1'b0;
			snap_page_reg  <= '0;
		end else begin
			snap_pulse_reg <= wr_ctrl & link.wr_data[CTRL_SNAP_BIT] & ~busy
				& (page_reg < PAGE_W'(NUM_PAGES));
			if (wr_ctrl & link.wr_data[CTRL_SNAP_BIT]) begin
				snap_page_reg <= page_reg;
			end
		end
	end

	// power-up page strap, caught once on the first edge after release
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			boot_taken_reg <= 1'b0;
			boot_page_reg  <= '0;
		end else if (~boot_taken_reg) begin
			boot_taken_reg <= 1'b1;
			boot_page_reg  <= boot_sel_pins;
		end
	end

	always_comb begin
		case (reg_ptr_reg)
			ADDR_CTRL: begin
				rd_mux = 8'h00;
				rd_mux[CTRL_BUSY_BIT] = busy;
			end
			ADDR_MEM_HI: begin
				rd_mux = {4'h0, mem_ptr_reg[11:8]};
			end
			ADDR_MEM_LO: begin
				rd_mux = mem_ptr_reg[7:0];
			end
			ADDR_ROM: begin
				rd_mux = rom_byte(rom_now);
			end
			ADDR_UNLOCK: begin
				rd_mux = unlock_reg;
			end
			ADDR_PAGE: begin
				rd_mux = {4'h0, page_reg};
			end
			ADDR_CAP_HI: begin
				rd_mux = {6'h00, xo_cap_value[9:8]};
			end
			ADDR_CAP_LO: begin
				rd_mux = xo_cap_value[7:0];
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rd_data_reg  <= RESET_BYTE;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= link.txn_act & link.rd_stb;
			if (link.txn_act & link.rd_stb) begin
				rd_data_reg <= rd_mux;
			end
		end
	end

	assign link.rd_data  = rd_data_reg;
	assign link.rd_valid = rd_valid_reg;
	assign prog_pulse    = prog_pulse_reg;
	assign prog_busy     = busy;
	assign snap_pulse    = snap_pulse_reg;
	assign snap_page     = snap_page_reg;
	assign boot_page     = boot_page_reg;
endmodule

// ==== design/oma_host.sv ====
// Purpose: host end - turns apb orders into link register transactions
// Assumes: single apb master; zero-wait slave
// Notes:   program and snapshot orders run two transactions back to back
`timescale 1ns/1ps
module oma_host (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	oma_link_if.host         link
);
	import oma_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_WR   = 3'b010,
		S_RD   = 3'b011,
		S_WAIT = 3'b100,
		S_END  = 3'b101
	} oma_state_t;

	oma_state_t  state_reg;
	oma_op_t     op_reg;
	logic        phase_reg;
	logic [7:0]  cnt_reg;
	logic [7:0]  arg_addr_reg;
	logic [7:0]  arg_data_reg;
	logic [7:0]  la_reg;
	logic [7:0]  ld_reg;
	logic [7:0]  rdata_reg;
	logic [7:0]  rcount_reg;
	logic        wr_acc;
	logic        start;
	logic [3:0]  pg;

	assign wr_acc = psel & penable & pwrite;
	assign start  = wr_acc & (paddr == HOST_CMD) & (state_reg == S_IDLE);
	// clamp to the last page and clear the reserved nibble
	assign pg = (arg_data_reg[3:0] > 4'(NUM_PAGES - 1))
		? 4'(NUM_PAGES - 1) : arg_data_reg[3:0];

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			arg_addr_reg <= 8'h00;
			arg_data_reg <= 8'h00;
		end else if (wr_acc & (paddr == HOST_ARG)) begin
			arg_addr_reg <= pwdata[7:0];
			arg_data_reg <= pwdata[15:8];
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_reg  <= S_IDLE;
			op_reg     <= OP_WRITE;
			phase_reg  <= 1'b0;
			cnt_reg    <= 8'h00;
			la_reg     <= 8'h00;
			ld_reg     <= 8'h00;
			rdata_reg  <= 8'h00;
			rcount_reg <= 8'h00;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (start) begin
						op_reg     <= oma_op_t'(pwdata[1:0]);
						phase_reg  <= 1'b0;
						rcount_reg <= 8'h00;
						cnt_reg    <= (pwdata[15:8] == 8'h00)
							? 8'h01 : pwdata[15:8];
						state_reg  <= S_ADDR;
						case (oma_op_t'(pwdata[1:0]))
							OP_PROG: begin
								la_reg <= ADDR_UNLOCK;
								ld_reg <= UNLOCK_KEY;
							end
							OP_SNAP: begin
								la_reg <= ADDR_PAGE;
								ld_reg <= {4'h0, pg};
							end
							default: begin
								la_reg <= arg_addr_reg;
								ld_reg <= arg_data_reg;
							end
						endcase
					end
				end
				S_ADDR: begin
					state_reg <= (op_reg == OP_READ) ? S_RD : S_WR;
				end
				S_WR: begin
					state_reg <= S_END;
				end
				S_RD: begin
					state_reg <= S_WAIT;
				end
				S_WAIT: begin
					if (link.rd_valid) begin
						rdata_reg  <= link.rd_data;
						rcount_reg <= rcount_reg + 8'h01;
						cnt_reg    <= cnt_reg - 8'h01;
						state_reg  <= (cnt_reg == 8'h01) ? S_END : S_RD;
					end
				end
				S_END: begin
					// control write follows the unlock or page write with nothing between
					if ((op_reg == OP_PROG || op_reg == OP_SNAP)
						&& !phase_reg) begin
						phase_reg <= 1'b1;
						la_reg    <= ADDR_CTRL;
						ld_reg    <= (op_reg == OP_PROG)
							? 8'h01 << CTRL_PROG_BIT
							: 8'h01 << CTRL_SNAP_BIT;
						state_reg <= S_ADDR;
					end else begin
						state_reg <= S_IDLE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	assign link.txn_act   = (state_reg != S_IDLE) && (state_reg != S_END);
	assign link.addr_load = (state_reg == S_ADDR);
	assign link.wr_stb    = (state_reg == S_WR);
	assign link.rd_stb    = (state_reg == S_RD);
	assign link.reg_addr  = la_reg;
	assign link.wr_data   = ld_reg;

	always_comb begin
		prdata = 32'h0000_0000;
		if (paddr == HOST_STAT) begin
			prdata = {8'h00, rcount_reg, rdata_reg, 7'h00,
				state_reg != S_IDLE};
		end else if (paddr == HOST_ARG) begin
			prdata = {16'h0000, arg_data_reg, arg_addr_reg};
		end
	end

	assign pready  = 1'b1;
	assign pslverr = 1'b0;
endmodule

// ==== bench/oma_link_assertions.sv ====
// Purpose: link protocol checker between host and device ends
// Assumes: single clk_sys domain, reset asynchronous active high
// Notes:   watches the link wires only, so it judges both ends at once
`timescale 1ns/1ps
module oma_link_assertions (
	input wire logic       clk_sys,
	input wire logic       reset,
	input wire logic       txn_act,
	input wire logic       addr_load,
	input wire logic       wr_stb,
	input wire logic       rd_stb,
	input wire logic       rd_valid,
	input wire logic [7:0] rd_data
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_read;
		rd_stb && txn_act;
	endsequence
	sequence s_answer;
		rd_valid ##1 !rd_valid;
	endsequence

	property p_rd_answer;
		s_read |=> s_answer;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer late or not a pulse");
	property p_rd_cause;
		rd_valid |-> $past(rd_stb && txn_act);
	endproperty
	a_rd_cause: assert property (p_rd_cause)
		else $error("read answer without request");
	property p_rd_hold;
		!rd_valid |-> $stable(rd_data);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved without answer");
	property p_strobe_txn;
		(wr_stb || rd_stb || addr_load) |-> txn_act;
	endproperty
	a_strobe_txn: assert property (p_strobe_txn)
		else $error("strobe outside transaction");
	property p_one_strobe;
		$onehot0({wr_stb, rd_stb, addr_load});
	endproperty
	a_one_strobe: assert property (p_one_strobe)
		else $error("two strobes in one cycle");
	property p_open_load;
		$rose(txn_act) |-> addr_load;
	endproperty
	a_open_load: assert property (p_open_load)
		else $error("transaction opened without address");
	property p_load_open;
		addr_load |-> $rose(txn_act);
	endproperty
	a_load_open: assert property (p_load_open)
		else $error("address load inside transaction");
	property p_rd_wait;
		rd_stb |=> !rd_stb && txn_act;
	endproperty
	a_rd_wait: assert property (p_rd_wait)
		else $error("read issued before answer");
endmodule

// ==== bench/onchip_memory_access_port_tb.sv ====
// Purpose: apb-driven bench joining host and device over the link
// Assumes: pready tied high by the host; results compared at the falling edge
// Notes:   expected reads and pulses are noted in queues by the driver
`timescale 1ns/1ps
module onchip_memory_access_port_tb;
	import oma_pkg::*;
	logic        clk_sys = 0, reset = 1, psel = 0, penable = 0;
	logic        pwrite = 0, rd_chk = 0, pready, pslverr;
	logic [11:0] paddr = 0, p;
	logic [31:0] pwdata = 0, prdata, rq;
	logic [9:0]  xo_cap_value = 0;
	logic [1:0]  boot_sel_pins = 0, boot_page;
	logic        prog_pulse, prog_busy, snap_pulse;
	logic [3:0]  snap_page;
	logic [31:0] exp_q[$];
	logic [4:0]  pul_q[$];
	int          n_fail = 0, checks_done = 0, cyc = 0, n_busy = 0;

	oma_link_if i_oma_link_if();
	oma_host i_oma_host (.clk_sys, .reset, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .link(i_oma_link_if));
	oma_dev #(.PROG_CYCLES(4)) i_oma_dev (.clk_sys, .reset,
		.link(i_oma_link_if), .xo_cap_value, .boot_sel_pins, .prog_pulse,
		.prog_busy, .snap_pulse, .snap_page, .boot_page);
	oma_link_assertions i_oma_link_assertions (.clk_sys(clk_sys),
		.reset(reset), .txn_act(i_oma_link_if.txn_act),
		.addr_load(i_oma_link_if.addr_load), .wr_stb(i_oma_link_if.wr_stb),
		.rd_stb(i_oma_link_if.rd_stb), .rd_valid(i_oma_link_if.rd_valid),
		.rd_data(i_oma_link_if.rd_data));

	always #20 clk_sys = ~clk_sys;

	function automatic logic [7:0] rom(input logic [11:0] a);
		return a[7:0] ^ {a[11:8], a[11:8]};
	endfunction

	task end_sim;
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	// one idle cycle after each transfer keeps drivers single-assigned
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic c);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		rd_chk <= c;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		// answer and read data are taken at the edge that sees pready
		while (pready !== 1'b1)
			@(posedge clk_sys);
		rq = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		rd_chk <= 1'b0;
		@(posedge clk_sys);
	endtask

	task op(input oma_op_t o, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] n);
		apb(1'b1, HOST_ARG, {16'h0, d, a}, 1'b0);
		apb(1'b1, HOST_CMD, {16'h0, n, 6'h0, o}, 1'b0);
		rq = 32'h1;
		while (rq[0] !== 1'b0 || prog_busy !== 1'b0)
			apb(1'b0, HOST_STAT, 32'h0, 1'b0);
	endtask

	task stat(input logic [7:0] n, input logic [7:0] d);
		exp_q.push_back({8'h0, n, d, 8'h0});
		apb(1'b0, HOST_STAT, 32'h0, 1'b1);
	endtask

	// falling edge: combinational prdata and one-cycle pulses are settled
	always @(negedge clk_sys) begin
		if (psel && penable && pready)
			chk("pslverr", 32'h0, pslverr);
		if (prog_busy === 1'b1)
			n_busy++;
		if (psel && penable && pready && rd_chk)
			chk("prdata", exp_q.size() ? exp_q.pop_front() : 'x, prdata);
		if (prog_pulse === 1'b1)
			chk("prog_pulse", pul_q.size() ? pul_q.pop_front() : 'x, 0);
		if (snap_pulse === 1'b1)
			chk("snap_page", pul_q.size() ? pul_q.pop_front() : 'x,
				{1'b1, snap_page});
	end

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 8000) begin
			n_fail++;
			end_sim;
		end
	end

	initial begin
		void'($urandom(75912));
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		boot_sel_pins <= $urandom;
		xo_cap_value <= $urandom;
		p = $urandom;
		repeat (2) @(posedge clk_sys);
		chk("boot_page", boot_sel_pins, boot_page);
		stat(8'h0, 8'h0);
		exp_q.push_back(32'h0);
		apb(1'b0, 12'h00c, 32'h0, 1'b1);
		op(OP_READ, ADDR_CAP_HI, 8'h0, 8'h2);
		stat(8'h2, xo_cap_value[7:0]);
		op(OP_READ, ADDR_CAP_HI, 8'h0, 8'h1);
		stat(8'h1, {6'h0, xo_cap_value[9:8]});
		op(OP_WRITE, ADDR_MEM_HI, {4'h0, p[11:8]}, 8'h0);
		op(OP_WRITE, ADDR_MEM_LO, p[7:0], 8'h0);
		op(OP_READ, ADDR_MEM_HI, 8'h0, 8'h2);
		stat(8'h2, p[7:0]);
		op(OP_READ, ADDR_ROM, 8'h0, 8'h1);
		stat(8'h1, rom(p));
		op(OP_READ, ADDR_ROM, 8'h0, 8'h3);
		stat(8'h3, rom(p + 12'h2));
		op(OP_READ, ADDR_ROM - 8'h1, 8'h0, 8'h3);
		stat(8'h3, rom(p + 12'h1));
		op(OP_WRITE, ADDR_UNLOCK, 8'h12, 8'h0);
		op(OP_READ, ADDR_ROM, 8'h0, 8'h1);
		op(OP_READ, ADDR_UNLOCK, 8'h0, 8'h1);
		stat(8'h1, 8'h12);
		// wrong key and an intervening write must both leave no pulse
		op(OP_WRITE, ADDR_CTRL, 8'h01, 8'h0);
		op(OP_WRITE, ADDR_UNLOCK, UNLOCK_KEY, 8'h0);
		op(OP_WRITE, ADDR_MEM_LO, p[7:0], 8'h0);
		op(OP_WRITE, ADDR_CTRL, 8'h01, 8'h0);
		pul_q.push_back(5'h0);
		op(OP_WRITE, ADDR_UNLOCK, UNLOCK_KEY, 8'h0);
		op(OP_WRITE, ADDR_CTRL, 8'h01, 8'h0);
		pul_q.push_back(5'h0);
		op(OP_PROG, 8'h0, 8'h0, 8'h0);
		for (int i = 0; i < 7; i++) begin
			pul_q.push_back({1'b1, i > 5 ? 4'h5 : i[3:0]});
			op(OP_SNAP, 8'h0, i[7:0], 8'h0);
		end
		// upper nibble of the page argument is reserved and must not count
		pul_q.push_back(5'h13);
		op(OP_SNAP, 8'h0, 8'hf3, 8'h0);
		// two program cycles of four busy cycles each with PROG_CYCLES 4
		chk("busy_cycles", 32'h8, 32'(n_busy));
		chk("notes_left", 32'h0, 32'(exp_q.size() + pul_q.size()));
		end_sim;
	end
endmodule
